// >>> rtl/csi_tx_timing_override.sv
// Lane-timing override register bank of the second camera-serial output port, with APB slave.
//
// Behaviour
// - With the data-trail override flag in bit 7 clear the automatic data-trail time is used, else bits 6:0.
// - With the data-exit override flag in bit 7 clear the automatic data-exit time is used, else bits 6:0.
// - With the turnaround override flag in bit 7 clear the automatic turnaround is used, else bits 6:0.
// - A value field ignores writes and reads the automatic value while its flag is clear, else it is read/write.
// - Data exit resets to 0xB for the default 800 Mbps rate and automatic values follow the lane rate.
`timescale 1ns/1ps
module csi_tx_timing_override (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [tx_timing_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [tx_timing_pkg::DATA_W-1:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [tx_timing_pkg::DATA_W-1:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic hs_active_in,
	output tx_timing_pkg::timing_set_t lane_timing_out,
	output logic hs_entry_out
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic [tx_timing_pkg::ADDR_W-1:0] byte_addr(input logic [7:0] index);
		return {index, 2'b00};
	endfunction

	function automatic tx_timing_pkg::reg_sel_t decode(input logic [tx_timing_pkg::ADDR_W-1:0] addr);
		tx_timing_pkg::reg_sel_t sel;
		sel = tx_timing_pkg::SEL_NONE;
		if (addr == byte_addr(tx_timing_pkg::TRAIL_INDEX)) begin
			sel = tx_timing_pkg::SEL_TRAIL;
		end else if (addr == byte_addr(tx_timing_pkg::EXIT_INDEX)) begin
			sel = tx_timing_pkg::SEL_EXIT;
		end else if (addr == byte_addr(tx_timing_pkg::TURN_INDEX)) begin
			sel = tx_timing_pkg::SEL_TURN;
		end else if (addr == byte_addr(tx_timing_pkg::RATE_INDEX)) begin
			sel = tx_timing_pkg::SEL_RATE;
		end else if (addr == byte_addr(tx_timing_pkg::STATUS_INDEX)) begin
			sel = tx_timing_pkg::SEL_STATUS;
		end
		return sel;
	endfunction

	// Parameter slot 0 is data trail, 1 is data exit, 2 is turnaround.
	function automatic logic [1:0] slot_of(input tx_timing_pkg::reg_sel_t sel);
		logic [1:0] slot;
		slot = 2'h3;
		if (sel == tx_timing_pkg::SEL_TRAIL) begin
			slot = 2'h0;
		end else if (sel == tx_timing_pkg::SEL_EXIT) begin
			slot = 2'h1;
		end else if (sel == tx_timing_pkg::SEL_TURN) begin
			slot = 2'h2;
		end
		return slot;
	endfunction

	// ----------------------------------------------------------------
	// Bus phase decode
	// ----------------------------------------------------------------
	tx_timing_pkg::reg_sel_t sel;
	logic [1:0] wr_slot;
	logic setup_phase;
	logic access_done;
	logic wr_ok;
	logic lane0_wr;

	assign sel = decode(paddr_in);
	assign wr_slot = slot_of(sel);
	assign setup_phase = clk_en_in && psel_in && !penable_in;
	// Zero wait states: the access phase completes on its first enabled edge.
	assign pready_out = clk_en_in;
	assign access_done = clk_en_in && psel_in && penable_in;
	assign lane0_wr = pstrb_in[0];
	assign wr_ok = access_done && pwrite_in && lane0_wr && (sel != tx_timing_pkg::SEL_NONE);

	// ----------------------------------------------------------------
	// Lane rate select and automatic timing
	// ----------------------------------------------------------------
	tx_timing_pkg::lane_rate_t rate_ff;
	tx_timing_pkg::timing_set_t auto_timing;
	logic [tx_timing_pkg::RATE_W-1:0] rate_wdata;

	assign rate_wdata = pwdata_in[tx_timing_pkg::RATE_W-1:0];

	// Codes beyond the last defined rate are ignored so the rate is always legal.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rate_ff <= tx_timing_pkg::RATE_RESET;
		end else if (wr_ok && sel == tx_timing_pkg::SEL_RATE) begin
			if (rate_wdata <= tx_timing_pkg::RATE_1600) begin
				rate_ff <= tx_timing_pkg::lane_rate_t'(rate_wdata);
			end
		end
	end

	lane_timing_calc u_calc (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.rate_in(rate_ff),
		.auto_timing_out(auto_timing)
	);

	// ----------------------------------------------------------------
	// Override flags and held values
	// ----------------------------------------------------------------
	logic [tx_timing_pkg::VAL_W-1:0] auto_val [tx_timing_pkg::NUM_PARAMS];
	logic [tx_timing_pkg::VAL_W-1:0] held_ff [tx_timing_pkg::NUM_PARAMS];
	logic [tx_timing_pkg::VAL_W-1:0] eff_val [tx_timing_pkg::NUM_PARAMS];
	logic [tx_timing_pkg::VAL_W-1:0] reset_val [tx_timing_pkg::NUM_PARAMS];
	logic ovr_ff [tx_timing_pkg::NUM_PARAMS];
	logic wr_flag;
	logic [tx_timing_pkg::VAL_W-1:0] wr_value;

	assign auto_val[0] = auto_timing.trail;
	assign auto_val[1] = auto_timing.exit;
	assign auto_val[2] = auto_timing.turnaround;
	assign reset_val[0] = tx_timing_pkg::TRAIL_RESET;
	assign reset_val[1] = tx_timing_pkg::EXIT_RESET;
	assign reset_val[2] = tx_timing_pkg::TURN_RESET;
	assign wr_flag = pwdata_in[tx_timing_pkg::OVR_FLAG_BIT];
	assign wr_value = pwdata_in[tx_timing_pkg::VAL_W-1:0];

	genvar g;
	generate
		for (g = 0; g < tx_timing_pkg::NUM_PARAMS; g++) begin : gen_param
			logic hit;

			assign hit = wr_ok && (wr_slot == 2'(g));

			always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					ovr_ff[g] <= tx_timing_pkg::OVR_FLAG_RESET;
				end else if (hit) begin
					ovr_ff[g] <= wr_flag;
				end
			end

			// While the flag is clear the held value shadows the automatic one and writes are dropped,
			// so setting the flag starts from the value software last read.
			always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					held_ff[g] <= reset_val[g];
				end else if (clk_en_in) begin
					if (!ovr_ff[g]) begin
						held_ff[g] <= auto_val[g];
					end else if (hit) begin
						held_ff[g] <= wr_value;
					end
				end
			end
		end
	endgenerate

	assign eff_val[0] = ovr_ff[0] ? held_ff[0] : auto_val[0];
	assign eff_val[1] = ovr_ff[1] ? held_ff[1] : auto_val[1];
	assign eff_val[2] = ovr_ff[2] ? held_ff[2] : auto_val[2];

	// ----------------------------------------------------------------
	// High-speed entry and applied timing
	// ----------------------------------------------------------------
	typedef enum logic {
		LINK_LP,
		LINK_HS
	} link_state_t;

	link_state_t link_ff;
	link_state_t nxt_link;
	tx_timing_pkg::timing_set_t applied_ff;
	tx_timing_pkg::timing_set_t nxt_applied;
	logic entry;

	always_comb begin
		nxt_link = link_ff;
		entry = 1'b0;
		unique case (link_ff)
			LINK_LP: begin
				if (hs_active_in) begin
					nxt_link = LINK_HS;
					entry = 1'b1;
				end
			end
			LINK_HS: begin
				if (!hs_active_in) begin
					nxt_link = LINK_LP;
				end
			end
		endcase
	end

	always_comb begin
		nxt_applied.trail = eff_val[0];
		nxt_applied.exit = eff_val[1];
		nxt_applied.turnaround = eff_val[2];
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link_ff <= LINK_LP;
		end else if (clk_en_in) begin
			link_ff <= nxt_link;
		end
	end

	// The timing is taken at each entry into high speed and held through the burst.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			applied_ff <= tx_timing_pkg::TIMING_800;
			hs_entry_out <= 1'b0;
		end else if (clk_en_in) begin
			hs_entry_out <= entry;
			if (entry) begin
				applied_ff <= nxt_applied;
			end
		end
	end

	assign lane_timing_out = applied_ff;

	// ----------------------------------------------------------------
	// Read data and error response
	// ----------------------------------------------------------------
	logic [tx_timing_pkg::DATA_W-1:0] rd_word;
	logic [1:0] rd_slot;

	assign rd_slot = slot_of(sel);

	always_comb begin
		rd_word = '0;
		unique case (sel)
			tx_timing_pkg::SEL_TRAIL, tx_timing_pkg::SEL_EXIT, tx_timing_pkg::SEL_TURN: begin
				rd_word[tx_timing_pkg::OVR_FLAG_BIT] = ovr_ff[rd_slot];
				rd_word[tx_timing_pkg::VAL_W-1:0] = eff_val[rd_slot];
			end
			tx_timing_pkg::SEL_RATE: begin
				rd_word[tx_timing_pkg::RATE_W-1:0] = rate_ff;
			end
			tx_timing_pkg::SEL_STATUS: begin
				rd_word[tx_timing_pkg::STATUS_TRAIL_LSB +: tx_timing_pkg::VAL_W] = applied_ff.trail;
				rd_word[tx_timing_pkg::STATUS_EXIT_LSB +: tx_timing_pkg::VAL_W] = applied_ff.exit;
				rd_word[tx_timing_pkg::STATUS_TURN_LSB +: tx_timing_pkg::VAL_W] = applied_ff.turnaround;
				rd_word[tx_timing_pkg::STATUS_HS_BIT] = (link_ff == LINK_HS);
			end
			tx_timing_pkg::SEL_NONE: begin
				rd_word = '0;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// Read data and the error flag are captured in the setup cycle and stand through the access phase.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prdata_out <= '0;
			pslverr_out <= 1'b0;
		end else if (setup_phase) begin
			prdata_out <= pwrite_in ? '0 : rd_word;
			pslverr_out <= (sel == tx_timing_pkg::SEL_NONE);
		end
	end

endmodule

// >>> rtl/lane_timing_calc.sv
// Automatic lane-timing calculation from the selected output lane rate.
`timescale 1ns/1ps
module lane_timing_calc (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire tx_timing_pkg::lane_rate_t rate_in,
	output tx_timing_pkg::timing_set_t auto_timing_out
);

	// ----------------------------------------------------------------
	// Rate lookup
	// ----------------------------------------------------------------
	function automatic tx_timing_pkg::timing_set_t lookup(input tx_timing_pkg::lane_rate_t rate);
		tx_timing_pkg::timing_set_t set;
		set = tx_timing_pkg::TIMING_800;
		unique case (rate)
			tx_timing_pkg::RATE_400: set = tx_timing_pkg::TIMING_400;
			tx_timing_pkg::RATE_800: set = tx_timing_pkg::TIMING_800;
			tx_timing_pkg::RATE_1200: set = tx_timing_pkg::TIMING_1200;
			tx_timing_pkg::RATE_1500: set = tx_timing_pkg::TIMING_1500;
			tx_timing_pkg::RATE_1600: set = tx_timing_pkg::TIMING_1600;
			default: set = tx_timing_pkg::TIMING_800;
		endcase
		return set;
	endfunction

	// ----------------------------------------------------------------
	// Registered result
	// ----------------------------------------------------------------
	tx_timing_pkg::timing_set_t auto_ff;

	// The automatic values track every change of the lane rate.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			auto_ff <= tx_timing_pkg::TIMING_800;
		end else if (clk_en_in) begin
			auto_ff <= lookup(rate_in);
		end
	end

	assign auto_timing_out = auto_ff;

endmodule

// >>> rtl/tx_timing_pkg.sv
// Package with register map, field layout, reset values and types of the lane-timing override bank.
package tx_timing_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int VAL_W = 7;
	localparam int NUM_PARAMS = 3;
	localparam int RATE_W = 3;

	// ----------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0] TRAIL_INDEX = 8'h66;
	localparam logic [7:0] EXIT_INDEX = 8'h67;
	localparam logic [7:0] TURN_INDEX = 8'h68;
	localparam logic [7:0] RATE_INDEX = 8'h70;
	localparam logic [7:0] STATUS_INDEX = 8'h71;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OVR_FLAG_BIT = 7;
	localparam int STATUS_TRAIL_LSB = 0;
	localparam int STATUS_EXIT_LSB = 8;
	localparam int STATUS_TURN_LSB = 16;
	localparam int STATUS_HS_BIT = 24;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [RATE_W-1:0] {
		RATE_400,
		RATE_800,
		RATE_1200,
		RATE_1500,
		RATE_1600
	} lane_rate_t;

	typedef enum logic [2:0] {
		SEL_TRAIL,
		SEL_EXIT,
		SEL_TURN,
		SEL_RATE,
		SEL_STATUS,
		SEL_NONE
	} reg_sel_t;

	typedef struct packed {
		logic [VAL_W-1:0] turnaround;
		logic [VAL_W-1:0] exit;
		logic [VAL_W-1:0] trail;
	} timing_set_t;

	// ----------------------------------------------------------------
	// Reset values and automatic timing per lane rate
	// ----------------------------------------------------------------
	localparam lane_rate_t RATE_RESET = RATE_800;
	localparam logic [VAL_W-1:0] TRAIL_RESET = 7'h08;
	localparam logic [VAL_W-1:0] EXIT_RESET = 7'h0b;
	localparam logic [VAL_W-1:0] TURN_RESET = 7'h06;
	localparam logic OVR_FLAG_RESET = 1'h0;
	localparam timing_set_t TIMING_800 = '{turnaround: TURN_RESET, exit: EXIT_RESET, trail: TRAIL_RESET};
	localparam timing_set_t TIMING_400 = '{turnaround: 7'h03, exit: 7'h06, trail: 7'h05};
	localparam timing_set_t TIMING_1200 = '{turnaround: 7'h09, exit: 7'h10, trail: 7'h0b};
	localparam timing_set_t TIMING_1500 = '{turnaround: 7'h0b, exit: 7'h14, trail: 7'h0d};
	localparam timing_set_t TIMING_1600 = '{turnaround: 7'h0c, exit: 7'h16, trail: 7'h0e};

endpackage

// >>> sim/csi_tx_timing_override_checker.sv
// Checker of the lane-timing override bank, watching its ports only.
`timescale 1ns/1ps
module csi_tx_timing_override_checker (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [tx_timing_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [tx_timing_pkg::DATA_W-1:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic pready_out,
	input wire logic hs_active_in,
	input wire tx_timing_pkg::timing_set_t lane_timing_out,
	input wire logic hs_entry_out
);
	logic [2:0] ovr_ff;
	logic [2:0] kn_ff;
	logic [2:0][6:0] val_ff;
	logic wr_acc;

	assign wr_acc = psel_in && penable_in && pwrite_in && pready_out && pstrb_in[0];

	// A value is known only once it was written while its override flag was already set.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ovr_ff <= '0;
			kn_ff <= '0;
			val_ff <= '0;
		end else if (wr_acc) begin
			for (int i = 0; i < 3; i++) begin
				if (paddr_in == {tx_timing_pkg::TRAIL_INDEX + 8'(i), 2'b00}) begin
					if (ovr_ff[i]) begin
						val_ff[i] <= pwdata_in[6:0];
						kn_ff[i] <= pwdata_in[7];
					end else begin
						kn_ff[i] <= 1'b0;
					end
					ovr_ff[i] <= pwdata_in[7];
				end
			end
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_trail; hs_entry_out && $past(kn_ff[0]) |-> lane_timing_out.trail == $past(val_ff[0]); endproperty
	a_trail: assert property (p_trail) else $error("applied trail differs from override");
	property p_exit; hs_entry_out && $past(kn_ff[1]) |-> lane_timing_out.exit == $past(val_ff[1]); endproperty
	a_exit: assert property (p_exit) else $error("applied exit differs from override");
	property p_turn; hs_entry_out && $past(kn_ff[2]) |-> lane_timing_out.turnaround == $past(val_ff[2]); endproperty
	a_turn: assert property (p_turn) else $error("applied turnaround differs from override");
	property p_reset_exit; $rose(rst_n_in) |-> lane_timing_out.exit == 7'h0b; endproperty
	a_reset_exit: assert property (p_reset_exit) else $error("exit time after reset wrong");
	property p_hold; !hs_entry_out |-> $stable(lane_timing_out); endproperty
	a_hold: assert property (p_hold) else $error("lane timing changed outside entry");
	property p_entry; hs_active_in && !$past(hs_active_in) && clk_en_in |=> hs_entry_out; endproperty
	a_entry: assert property (p_entry) else $error("no entry pulse after high speed start");
	property p_pulse; hs_entry_out && clk_en_in |=> !hs_entry_out; endproperty
	a_pulse: assert property (p_pulse) else $error("entry pulse longer than one cycle");
	property p_cause; hs_entry_out |-> $past(hs_active_in); endproperty
	a_cause: assert property (p_cause) else $error("entry pulse without high speed");
endmodule

bind csi_tx_timing_override csi_tx_timing_override_checker chk_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
	.clk_en_in(clk_en_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .pready_out(pready_out), .hs_active_in(hs_active_in),
	.lane_timing_out(lane_timing_out), .hs_entry_out(hs_entry_out));

// >>> sim/csi_tx_timing_override_tb_top.sv
// Self-checking testbench of the lane-timing override bank.
`timescale 1ns/1ps
module csi_tx_timing_override_tb_top;
	logic ref_clk_in, rst_n_in, clk_en_in, psel_in, penable_in, pwrite_in, hs_active_in;
	logic [9:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out;
	logic [3:0] pstrb_in;
	logic pready_out, pslverr_out, hs_entry_out;
	tx_timing_pkg::timing_set_t lane_timing_out;
	logic [32:0] rd_q[$];
	tx_timing_pkg::timing_set_t lane_q[$];
	logic [6:0] val[3];
	logic flg[3];
	int rate, num_errors, tests_run;

	csi_tx_timing_override DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .hs_active_in(hs_active_in), .lane_timing_out(lane_timing_out),
		.hs_entry_out(hs_entry_out));

	always #20 ref_clk_in = ~ref_clk_in;

	// ----------------------------------------------------------------
	// Expected-value model
	// ----------------------------------------------------------------
	function automatic logic [6:0] auto_v(int r, int i);
		tx_timing_pkg::timing_set_t t;
		case (r)
			0: t = tx_timing_pkg::TIMING_400;
			2: t = tx_timing_pkg::TIMING_1200;
			3: t = tx_timing_pkg::TIMING_1500;
			4: t = tx_timing_pkg::TIMING_1600;
			default: t = tx_timing_pkg::TIMING_800;
		endcase
		return 7'(t >> (7 * i));
	endfunction

	function automatic logic [6:0] eff(int i);
		return flg[i] ? val[i] : auto_v(rate, i);
	endfunction

	task automatic chk(string name, logic [32:0] seen, logic [32:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Drivers
	// ----------------------------------------------------------------
	task automatic idle(int n);
		psel_in <= 1'b0;
		repeat (n) @(posedge ref_clk_in);
	endtask

	task automatic apb(logic w, logic [9:0] a, logic [31:0] d, logic [32:0] e);
		int n;
		n = 0;
		if (!w) rd_q.push_back(e);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		if (n >= 20) num_errors++;
		penable_in <= 1'b0;
	endtask

	task automatic rd(int i);
		apb(1'b0, {tx_timing_pkg::TRAIL_INDEX + 8'(i), 2'b00}, 32'h0, {1'b0, 24'h0, flg[i], eff(i)});
	endtask

	task automatic wr(int i, logic [7:0] d);
		apb(1'b1, {tx_timing_pkg::TRAIL_INDEX + 8'(i), 2'b00}, {24'h0, d}, 33'h0);
		if (flg[i]) val[i] = d[6:0];
		else if (d[7]) val[i] = auto_v(rate, i);
		flg[i] = d[7];
	endtask

	task automatic set_rate(int r);
		apb(1'b1, {tx_timing_pkg::RATE_INDEX, 2'b00}, 32'(r), 33'h0);
		if (r < 5) rate = r;
		idle(2);
	endtask

	task automatic entry(int i, logic [7:0] d, bit mid);
		lane_q.push_back({eff(2), eff(1), eff(0)});
		hs_active_in <= 1'b1;
		idle(1);
		if (mid) wr(i, d);
		idle(1);
		hs_active_in <= 1'b0;
		idle(1);
	endtask

	task automatic do_reset();
		rst_n_in <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		rate = 1;
		for (int i = 0; i < 3; i++) flg[i] = 1'b0;
	endtask

	always @(negedge ref_clk_in) begin
		if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1) begin
			chk("read", {pslverr_out, prdata_out}, rd_q.pop_front());
		end
		if (hs_entry_out === 1'b1) begin
			chk("lane", 33'(lane_timing_out), 33'(lane_q.pop_front()));
		end
	end

	initial begin
		repeat (20000) @(posedge ref_clk_in);
		num_errors++;
		print_verdict();
	end

	initial begin
		ref_clk_in = 0; rst_n_in = 0; clk_en_in = 1; psel_in = 0; penable_in = 0; pwrite_in = 0;
		paddr_in = '0; pwdata_in = '0; pstrb_in = 4'hf; hs_active_in = 0; num_errors = 0; tests_run = 0;
		void'($urandom(32'he553));
		do_reset();
		for (int i = 0; i < 3; i++) rd(i);
		entry(0, 8'h0, 0);
		for (int r = 0; r < 5; r++) begin
			set_rate(r);
			for (int i = 0; i < 3; i++) begin
				wr(i, {1'b0, 7'($urandom)});
				rd(i);
			end
			entry(0, 8'h0, 0);
		end
		set_rate(7);
		rd(0);
		for (int i = 0; i < 3; i++) begin
			wr(i, {1'b1, 7'($urandom)});
			rd(i);
			wr(i, {1'b1, 7'($urandom)});
			rd(i);
		end
		set_rate(3);
		entry(0, 8'h0, 0);
		entry(1, {1'b1, 7'($urandom)}, 1);
		entry(0, 8'h0, 0);
		for (int i = 0; i < 3; i++) begin
			wr(i, 8'h00);
			rd(i);
		end
		entry(0, 8'h0, 0);
		apb(1'b0, 10'h3fc, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 10'h3fc, $urandom, 33'h0);
		idle(1);
		do_reset();
		for (int i = 0; i < 3; i++) rd(i);
		entry(0, 8'h0, 0);
		idle(2);
		print_verdict();
	end
endmodule
